// ---- rtl/msd_cfg.svh ----
// Purpose: Offsets, field positions, reset values and limits of the message decoder
// Assumes: Included by bare name from every design file that needs it
// Notes: Definitions only
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH

`define MSD_OFF_REF0 8'h00
`define MSD_OFF_REF1 8'h04
`define MSD_OFF_SRC 8'h08
`define MSD_OFF_CTRL 8'h0c
`define MSD_OFF_SKIP 8'h10
`define MSD_OFF_AUX 8'h14
`define MSD_OFF_PIC 8'h18
`define MSD_OFF_MAP 8'h1c
`define MSD_OFF_STAT 8'h20
`define MSD_OFF_CLAMP 8'h24
`define MSD_OFF_WALK 8'h28

`define MSD_DUAL_PATH_BIT 11
`define MSD_SEL_HI 10
`define MSD_SEL_LO 8
`define MSD_REF_FETCH_BIT 7
`define MSD_SRC_FETCH_BIT 6
`define MSD_MAP_HI 5
`define MSD_MAP_LO 4
`define MSD_SIZE_HI 1
`define MSD_SIZE_LO 0
`define MSD_SKIP_HI 31
`define MSD_SKIP_LO 24
`define MSD_SHAPE_BIT 23
`define MSD_PENALTY_BIT 22
`define MSD_DC_BIT 21
`define MSD_WEIGHT_BIT 20

`define MSD_CTRL_MASK 32'h00000ff3
`define MSD_SKIP_MASK 32'hfff00000
`define MSD_RESET_WORD 32'h00000000
`define MSD_BIDIR_OFF 4'hf
`define MSD_ADAPT_MIN_LEN 8'h02
`define MSD_OFFSET_MIN 16'shf800
`define MSD_OFFSET_MAX 16'sh07ff

`endif

// ---- rtl/msd_decoder.sv ----
// Purpose: APB register slave that decodes motion search message controls
// Assumes: Zero wait state APB, 8-bit byte address, 32-bit data
// Notes: Probe registers answer remap, edge replication and walk questions
// Functional notes
// - Dual records with path option set: record 0 even entries, record 1 odd.
// - Search selector bits 10:8; only codes 000, 001, 011, 111 are valid.
// - Code 000: reference 0, one start and record; adaptive needs unit length two.
// - Code 001: start 0, then start 1, path from start 1, then adaptive.
// - Code 011: two records merged after integer search; refine only the best.
// - Code 111: both references, refine each record, merge per subblock.
// - Dual reference with partition mask 1111b disables bidirectional estimation.
// - Bit 7 selects frame or field reference fetch; should equal source bit.
// - Bit 6 selects frame or field source fetch.
// - Bits 5:4 remap inter output type forward or backward; ignored when intra.
// - Bits 1:0 source size 16x16, 16x8, 8x8; 10b reserved; small uses larger unit.
// - Reference pixels outside the picture are made by edge replication.
// - Region offsets are signed pixels, accepted only from -2048 to 2047.
// - Skip enable bits 31:24 alternate reference 0 and 1 per center.
// - Bit 23 selects 16x16 or 8x8 distortion map shapes.
// - Bit 22 selects standard or linear reference index penalty.
// - Bit 21 set drops DC and sums only AC transform terms.
// - Bit 20 forces whole 16x16 accumulation; only 16x16 reference 0 searches.
// - Fields not applicable to the message kind are ignored.
`include "msd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module msd_decoder (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output msd_pkg::msd_decode_s decode,
    output msd_pkg::msd_error_s errors
);
    logic [31:0] ref0_reg;
    logic [31:0] ref1_reg;
    logic [31:0] src_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] skip_reg;
    logic [31:0] aux_reg;
    logic [31:0] pic_reg;
    logic [31:0] map_reg;
    logic [31:0] clamp_reg;
    logic [31:0] walk_reg;
    logic [31:0] prdata_next;
    logic pslverr_next;
    logic setup;
    logic wr_access;
    logic mapped;
    msd_pkg::msd_decode_s decode_next;
    msd_pkg::msd_error_s errors_next;

    // Message fields
    msd_pkg::msd_kind_e kind;
    logic [2:0] sel_raw;
    logic [2:0] sel;
    logic [1:0] mapping;
    logic [1:0] src_size;
    logic adaptive_walk_enable;
    logic [7:0] search_unit_length;
    logic [7:0] fixed_path_length;
    logic [3:0] bidirectional_partition_mask;
    logic skip_four_vector_pairs;
    logic is_sic;
    logic is_ime;
    logic is_fbr;
    logic is_idm;
    logic [3:0] pair_alive;
    logic [4:0] remapped;
    logic [15:0] clamp_x;
    logic [15:0] clamp_y;
    logic [15:0] region_x;
    logic [15:0] region_y;
    logic [7:0] walk_step;
    logic walk_record;
    logic [7:0] walk_index;
    logic walk_origin;
    logic walk_valid;
    msd_pkg::msd_phase_e walk_phase;

    assign kind = msd_pkg::msd_kind_e'(aux_reg[1:0]);
    assign adaptive_walk_enable = aux_reg[4];
    assign search_unit_length = aux_reg[15:8];
    assign fixed_path_length = aux_reg[23:16];
    assign bidirectional_partition_mask = aux_reg[27:24];
    assign skip_four_vector_pairs = aux_reg[28];
    assign sel_raw = ctrl_reg[`MSD_SEL_HI:`MSD_SEL_LO];
    assign mapping = ctrl_reg[`MSD_MAP_HI:`MSD_MAP_LO];
    assign src_size = ctrl_reg[`MSD_SIZE_HI:`MSD_SIZE_LO];
    assign is_sic = (kind == msd_pkg::MSD_KIND_SIC);
    assign is_ime = (kind == msd_pkg::MSD_KIND_IME);
    assign is_fbr = (kind == msd_pkg::MSD_KIND_FBR);
    assign is_idm = (kind == msd_pkg::MSD_KIND_IDM);
    assign sel = is_ime ? sel_raw : 3'h0;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pair
            assign pair_alive[gi] = skip_reg[`MSD_SKIP_LO + 2 * gi]
                | skip_reg[`MSD_SKIP_LO + 2 * gi + 1];
        end
    endgenerate

    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    // Zero wait states keep the master simple
    assign pready = 1'b1;

    always_comb
    begin
        case (paddr)
            `MSD_OFF_REF0, `MSD_OFF_REF1, `MSD_OFF_SRC, `MSD_OFF_CTRL,
            `MSD_OFF_SKIP, `MSD_OFF_AUX, `MSD_OFF_PIC, `MSD_OFF_MAP,
            `MSD_OFF_STAT, `MSD_OFF_CLAMP, `MSD_OFF_WALK:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    // Message words
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref0_reg <= `MSD_RESET_WORD;
            ref1_reg <= `MSD_RESET_WORD;
            src_reg <= `MSD_RESET_WORD;
            ctrl_reg <= `MSD_RESET_WORD;
            skip_reg <= `MSD_RESET_WORD;
            aux_reg <= `MSD_RESET_WORD;
            pic_reg <= `MSD_RESET_WORD;
        end
        else if (wr_access)
        begin
            case (paddr)
                `MSD_OFF_REF0: ref0_reg <= pwdata;
                `MSD_OFF_REF1: ref1_reg <= pwdata;
                `MSD_OFF_SRC: src_reg <= pwdata;
                // Reserved bits 3:2 and above 11 stay zero
                `MSD_OFF_CTRL: ctrl_reg <= pwdata & `MSD_CTRL_MASK;
                `MSD_OFF_SKIP: skip_reg <= pwdata & `MSD_SKIP_MASK;
                `MSD_OFF_AUX: aux_reg <= {3'h0, pwdata[28:8], 3'h0, pwdata[4], 2'h0, pwdata[1:0]};
                `MSD_OFF_PIC: pic_reg <= pwdata;
                default: ;
            endcase
        end
    end

    // Probe words
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            map_reg <= `MSD_RESET_WORD;
            clamp_reg <= `MSD_RESET_WORD;
            walk_reg <= `MSD_RESET_WORD;
        end
        else if (wr_access)
        begin
            case (paddr)
                `MSD_OFF_MAP: map_reg <= {23'h0, pwdata[8], 3'h0, pwdata[4:0]};
                `MSD_OFF_CLAMP: clamp_reg <= {15'h0, pwdata[16:0]};
                `MSD_OFF_WALK: walk_reg <= {23'h0, pwdata[8:0]};
                default: ;
            endcase
        end
    end

    // output type remap, intra bypass inside
    msd_type_remap u_remap (
        .mapping((is_ime || is_fbr) ? mapping : 2'h0),
        .intra(map_reg[8]),
        .type_in(map_reg[4:0]),
        .type_out(remapped)
    );

    assign region_x = clamp_reg[16] ? ref1_reg[15:0] : ref0_reg[15:0];
    assign region_y = clamp_reg[16] ? ref1_reg[31:16] : ref0_reg[31:16];

    msd_edge_clamp u_clamp_x (
        .base(region_x),
        .delta(clamp_reg[7:0]),
        .limit(pic_reg[15:0]),
        .pos(clamp_x)
    );

    msd_edge_clamp u_clamp_y (
        .base(region_y),
        .delta(clamp_reg[15:8]),
        .limit(pic_reg[31:16]),
        .pos(clamp_y)
    );

    assign walk_step = walk_reg[7:0];
    assign walk_record = walk_reg[8];

    // Which search unit a record visits at a given step
    always_comb
    begin
        walk_valid = !walk_record || decode_next.dual_record;
        walk_origin = walk_record;
        walk_index = 8'h00;
        walk_phase = msd_pkg::MSD_PH_DONE;
        if (walk_valid)
        begin
            if (sel == 3'(msd_pkg::MSD_SEL_DUAL_START))
            begin
                // both starts, then path from start 1
                walk_origin = (walk_step != 8'h00);
                if (walk_step < 8'h02)
                    walk_phase = msd_pkg::MSD_PH_START;
                else if (walk_step < fixed_path_length)
                begin
                    walk_phase = msd_pkg::MSD_PH_PATH;
                    walk_index = walk_step - 8'h02;
                end
                else if (adaptive_walk_enable)
                    walk_phase = msd_pkg::MSD_PH_ADAPT;
            end
            else
            begin
                if (walk_step == 8'h00)
                    walk_phase = msd_pkg::MSD_PH_START;
                else if (walk_step < fixed_path_length)
                begin
                    walk_phase = msd_pkg::MSD_PH_PATH;
                    if (decode_next.split_paths)
                        walk_index = {walk_step[6:0] - 7'h01, walk_record};
                    else
                        walk_index = walk_step - 8'h01;
                end
                else if (adaptive_walk_enable)
                    walk_phase = msd_pkg::MSD_PH_ADAPT;
            end
        end
    end

    // Decode of the message controls
    always_comb
    begin
        decode_next = '0;
        errors_next = '0;
        errors_next.code_err = is_ime && !(sel_raw == 3'(msd_pkg::MSD_SEL_SINGLE)
            || sel_raw == 3'(msd_pkg::MSD_SEL_DUAL_START)
            || sel_raw == 3'(msd_pkg::MSD_SEL_DUAL_RECORD)
            || sel_raw == 3'(msd_pkg::MSD_SEL_DUAL_REF));
        decode_next.dual_ref = (sel == 3'(msd_pkg::MSD_SEL_DUAL_REF));
        decode_next.dual_record = (sel == 3'(msd_pkg::MSD_SEL_DUAL_RECORD))
            || decode_next.dual_ref;
        decode_next.dual_cost = decode_next.dual_record;
        decode_next.dual_start = decode_next.dual_record
            || (sel == 3'(msd_pkg::MSD_SEL_DUAL_START));
        decode_next.merge_before_subpel = (sel == 3'(msd_pkg::MSD_SEL_DUAL_RECORD));
        decode_next.merge_per_subblock = decode_next.dual_ref;
        decode_next.bidir_on = decode_next.dual_ref
            && (bidirectional_partition_mask != `MSD_BIDIR_OFF);
        decode_next.split_paths = decode_next.dual_record && ctrl_reg[`MSD_DUAL_PATH_BIT];
        errors_next.adapt_len_err = is_ime && (sel == 3'(msd_pkg::MSD_SEL_SINGLE))
            && adaptive_walk_enable && (search_unit_length < `MSD_ADAPT_MIN_LEN);
        decode_next.src_field = ctrl_reg[`MSD_SRC_FETCH_BIT];
        decode_next.ref_field = ctrl_reg[`MSD_REF_FETCH_BIT];
        errors_next.access_mismatch = decode_next.src_field != decode_next.ref_field;
        errors_next.remap_err = (is_ime || is_fbr) && (mapping == 2'h3);
        decode_next.half_height = src_size[0];
        decode_next.half_width = src_size[1] && src_size[0];
        errors_next.size_err = (src_size == 2'h2);
        if (is_ime || is_idm)
            errors_next.range_err = $signed(ref0_reg[15:0]) < `MSD_OFFSET_MIN
                || $signed(ref0_reg[15:0]) > `MSD_OFFSET_MAX
                || $signed(ref0_reg[31:16]) < `MSD_OFFSET_MIN
                || $signed(ref0_reg[31:16]) > `MSD_OFFSET_MAX;
        if (decode_next.dual_ref)
            errors_next.range_err = errors_next.range_err
                || $signed(ref1_reg[15:0]) < `MSD_OFFSET_MIN
                || $signed(ref1_reg[15:0]) > `MSD_OFFSET_MAX
                || $signed(ref1_reg[31:16]) < `MSD_OFFSET_MIN
                || $signed(ref1_reg[31:16]) > `MSD_OFFSET_MAX;
        if (is_sic)
        begin
            decode_next.skip_enables = skip_reg[`MSD_SKIP_HI:`MSD_SKIP_LO];
            errors_next.skip_err = skip_four_vector_pairs ? (pair_alive != 4'hf)
                : !pair_alive[0];
        end
        decode_next.shape8x8 = is_idm && skip_reg[`MSD_SHAPE_BIT];
        decode_next.linear_penalty = skip_reg[`MSD_PENALTY_BIT];
        decode_next.dc_suppress = !is_idm && skip_reg[`MSD_DC_BIT];
        decode_next.weighted_on = (is_ime || is_idm) && skip_reg[`MSD_WEIGHT_BIT];
        errors_next.weighted_err = decode_next.weighted_on
            && ((src_size != 2'h0) || (sel != 3'(msd_pkg::MSD_SEL_SINGLE)));
    end

    // Decoded state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            decode <= '0;
            errors <= '0;
        end
        else
        begin
            decode <= decode_next;
            errors <= errors_next;
        end
    end

    always_comb
    begin
        prdata_next = 32'h00000000;
        case (paddr)
            `MSD_OFF_REF0: prdata_next = ref0_reg;
            `MSD_OFF_REF1: prdata_next = ref1_reg;
            `MSD_OFF_SRC: prdata_next = src_reg;
            `MSD_OFF_CTRL: prdata_next = ctrl_reg;
            `MSD_OFF_SKIP: prdata_next = skip_reg;
            `MSD_OFF_AUX: prdata_next = aux_reg;
            `MSD_OFF_PIC: prdata_next = pic_reg;
            `MSD_OFF_MAP: prdata_next = {11'h0, remapped, 7'h0, map_reg[8], 3'h0, map_reg[4:0]};
            `MSD_OFF_STAT: prdata_next = {decode, errors};
            `MSD_OFF_CLAMP: prdata_next = {clamp_y, clamp_x};
            `MSD_OFF_WALK: prdata_next = {20'h0, walk_valid, walk_phase, walk_origin, walk_index};
            default: prdata_next = 32'h00000000;
        endcase
        pslverr_next = !mapped;
    end

    // Answer captured in setup, stands through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h00000000 : prdata_next;
            pslverr <= pslverr_next;
        end
    end

endmodule : msd_decoder
`default_nettype wire

// ---- rtl/msd_edge_clamp.sv ----
// Purpose: Maps a reference pixel coordinate onto the picture by edge replication
// Assumes: Picture dimension in pixels, zero treated as one
// Notes: Outside pixels take the nearest edge pixel
`include "msd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module msd_edge_clamp (
    input wire logic [15:0] base,
    input wire logic [7:0] delta,
    input wire logic [15:0] limit,
    output logic [15:0] pos
);
    logic signed [17:0] sum;

    always_comb
    begin
        sum = 18'($signed(base)) + 18'($signed(delta));
        if (sum < 18'sd0)
            pos = 16'h0000;
        else if (limit == 16'h0000)
            pos = 16'h0000;
        else if (sum >= $signed({2'b00, limit}))
            pos = limit - 16'h0001;
        else
            pos = sum[15:0];
    end
endmodule : msd_edge_clamp
`default_nettype wire

// ---- rtl/msd_pkg.sv ----
// Purpose: Types shared by the message decoder files
// Assumes: Constants live in msd_cfg.svh
// Notes: Used only with explicit package scope
`default_nettype none
package msd_pkg;

    typedef enum logic [1:0] {
        MSD_KIND_SIC = 2'h0,
        MSD_KIND_IME = 2'h1,
        MSD_KIND_FBR = 2'h2,
        MSD_KIND_IDM = 2'h3
    } msd_kind_e;

    typedef enum logic [2:0] {
        MSD_SEL_SINGLE = 3'h0,
        MSD_SEL_DUAL_START = 3'h1,
        MSD_SEL_DUAL_RECORD = 3'h3,
        MSD_SEL_DUAL_REF = 3'h7
    } msd_sel_e;

    // Gray order along a walk: start, fixed path, adaptive, done
    typedef enum logic [1:0] {
        MSD_PH_START = 2'h0,
        MSD_PH_PATH = 2'h1,
        MSD_PH_ADAPT = 2'h3,
        MSD_PH_DONE = 2'h2
    } msd_phase_e;

    typedef struct packed {
        logic dual_ref;
        logic dual_record;
        logic dual_start;
        logic dual_cost;
        logic merge_before_subpel;
        logic merge_per_subblock;
        logic bidir_on;
        logic split_paths;
        logic src_field;
        logic ref_field;
        logic half_height;
        logic half_width;
        logic shape8x8;
        logic linear_penalty;
        logic dc_suppress;
        logic weighted_on;
        logic [7:0] skip_enables;
    } msd_decode_s;

    typedef struct packed {
        logic access_mismatch;
        logic weighted_err;
        logic skip_err;
        logic range_err;
        logic adapt_len_err;
        logic size_err;
        logic remap_err;
        logic code_err;
    } msd_error_s;

endpackage : msd_pkg
`default_nettype wire

// ---- rtl/msd_type_remap.sv ----
// Purpose: Remaps an inter output block type to one direction
// Assumes: Type codes 0..16h, five bits
// Notes: Reserved mapping code and intra outputs pass unchanged
`include "msd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module msd_type_remap (
    input wire logic [1:0] mapping,
    input wire logic intra,
    input wire logic [4:0] type_in,
    output logic [4:0] type_out
);
    always_comb
    begin
        type_out = type_in;
        if (!intra && (mapping == 2'h1 || mapping == 2'h2))
        begin
            if (type_in >= 5'h01 && type_in <= 5'h03)
                type_out = (mapping == 2'h1) ? 5'h01 : 5'h02;
            else if (type_in >= 5'h04 && type_in <= 5'h15)
            begin
                if (type_in[0])
                    type_out = (mapping == 2'h1) ? 5'h05 : 5'h07;
                else
                    type_out = (mapping == 2'h1) ? 5'h04 : 5'h06;
            end
        end
    end
endmodule : msd_type_remap
`default_nettype wire

// ---- tb/msd_decoder_checker.sv ----
// Purpose: Concurrent checks on decoded message controls
// Assumes: Writes land at the access edge, decode follows one clock later
// Notes: Shadows the control, skip and aux registers from the bus
`include "msd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module msd_decoder_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire msd_pkg::msd_decode_s decode,
    input wire msd_pkg::msd_error_s errors
);
    logic [31:0] ctrl_reg;
    logic [31:0] skip_reg;
    logic [31:0] aux_reg;
    logic [2:0] sel;
    logic ok;
    // Other kinds act as selector 000
    assign sel = (aux_reg[1:0] == 2'h1) ? ctrl_reg[`MSD_SEL_HI:`MSD_SEL_LO] : 3'h0;
    assign ok = sel inside {3'h0, 3'h1, 3'h3, 3'h7};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= `MSD_RESET_WORD;
            skip_reg <= `MSD_RESET_WORD;
            aux_reg <= `MSD_RESET_WORD;
        end
        else if (psel && penable && pwrite)
        begin
            case (paddr)
                `MSD_OFF_CTRL: ctrl_reg <= pwdata;
                `MSD_OFF_SKIP: skip_reg <= pwdata;
                `MSD_OFF_AUX: aux_reg <= pwdata;
                default: ;
            endcase
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_split;
        ok && sel[1] |=> decode.split_paths == $past(ctrl_reg[`MSD_DUAL_PATH_BIT]);
    endproperty
    a_split: assert property (p_split) else $error("split path flag wrong");
    property p_code;
        errors.code_err == !$past(ok);
    endproperty
    a_code: assert property (p_code) else $error("selector code flag wrong");
    property p_start;
        ok && sel == 3'h1 |=> decode.dual_start && !decode.dual_record && !decode.dual_ref;
    endproperty
    a_start: assert property (p_start) else $error("dual start decode wrong");
    property p_ref;
        ok && sel == 3'h7 |=> decode.dual_ref && decode.merge_per_subblock;
    endproperty
    a_ref: assert property (p_ref) else $error("dual reference decode wrong");
    property p_bidir;
        ok && sel == 3'h7 |=> decode.bidir_on == $past(aux_reg[27:24] != `MSD_BIDIR_OFF);
    endproperty
    a_bidir: assert property (p_bidir) else $error("bidirectional enable wrong");
    property p_fetch;
        {decode.ref_field, decode.src_field, errors.access_mismatch}
            == $past({ctrl_reg[7], ctrl_reg[6], ctrl_reg[7] ^ ctrl_reg[6]});
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch kind decode wrong");
    property p_size;
        ctrl_reg[1:0] != 2'h2 |=> {decode.half_height, decode.half_width}
            == $past({ctrl_reg[0], ctrl_reg[1]});
    endproperty
    a_size: assert property (p_size) else $error("block size decode wrong");
    property p_skip;
        decode.skip_enables == $past(aux_reg[1:0] == 2'h0 ? skip_reg[31:24] : 8'h00);
    endproperty
    a_skip: assert property (p_skip) else $error("skip enables wrong");
    property p_shape;
        decode.shape8x8 == $past(aux_reg[1:0] == 2'h3 && skip_reg[`MSD_SHAPE_BIT]);
    endproperty
    a_shape: assert property (p_shape) else $error("map shape wrong");
    property p_pen;
        $rose(skip_reg[`MSD_PENALTY_BIT]) |=> decode.linear_penalty;
    endproperty
    a_pen: assert property (p_pen) else $error("penalty mode late");
endmodule : msd_decoder_checker
bind msd_decoder msd_decoder_checker u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .decode, .errors);
`default_nettype wire

// ---- tb/msd_issuer.sv ----
// Purpose: Issuing thread model, masters the register bus
// Assumes: Called just after a rising edge or from the bench sequence
// Notes: Released lines carry inverted junk, never the last value
`timescale 1ns/1ps
`default_nettype none
module msd_issuer (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= ~pwrite;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : msd_issuer
`default_nettype wire

// ---- tb/tb_msd_decoder.sv ----
// Purpose: Self-checking bench for the message decoder
// Assumes: Status word is {decode, errors}
// Notes: Issuer model drives every bus cycle
`include "msd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_msd_decoder;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    msd_pkg::msd_decode_s decode;
    msd_pkg::msd_error_s errors;
    int fails = 0;
    int comparisons = 0;
    // Remap table: mapping [12:11], intra [10], type in [9:5], type out [4:0]
    logic [12:0] remap_tab [9] = '{13'h0861, 13'h0904, 13'h0925, 13'h0ad6, 13'h1042,
        13'h1286, 13'h12a7, 13'h0d29, 13'h0129};
    msd_issuer u_iss (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr);
    msd_decoder uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .decode, .errors);
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_iss.xfer(1'b1, a, d, q, e);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        u_iss.xfer(1'b0, a, 32'h00000000, q, e);
        check(q & m, exp);
    endtask : rd_chk
    task wr_st(input logic [7:0] a, input logic [31:0] d, m, exp);
        wr(a, d);
        rd_chk(`MSD_OFF_STAT, m, exp);
    endtask : wr_st
    task end_sim;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    initial
    begin
        #40000;
        fails++;
        end_sim();
    end
    initial
    begin
        logic [2:0] s;
        logic [1:0] j;
        logic [12:0] t;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`MSD_OFF_STAT, 32'hffffffff, 32'h00000020);
        wr(`MSD_OFF_SRC, 32'h00200010);
        wr(`MSD_OFF_AUX, 32'h00000001);
        for (int i = 0; i < 8; i++)
        begin
            s = i[2:0];
            wr(`MSD_OFF_CTRL, {21'h0, s, 8'h00});
            if (s inside {3'h0, 3'h1, 3'h3, 3'h7})
                rd_chk(`MSD_OFF_STAT, 32'hfc000001, {s == 3'h7, s[1], s != 3'h0, s[1],
                    s == 3'h3, s == 3'h7, 26'h0});
            else
                rd_chk(`MSD_OFF_STAT, 32'h00000001, 32'h00000001);
        end
        wr_st(`MSD_OFF_AUX, 32'h0f000001, 32'h02000000, 32'h00000000);
        wr_st(`MSD_OFF_AUX, 32'h0e000001, 32'h02000000, 32'h02000000);
        wr_st(`MSD_OFF_CTRL, 32'h00000b00, 32'h01000000, 32'h01000000);
        wr(`MSD_OFF_AUX, 32'h00100001);
        wr(`MSD_OFF_WALK, 32'h00000103);
        rd_chk(`MSD_OFF_WALK, 32'h000000ff, 32'h00000005);
        wr(`MSD_OFF_CTRL, 32'h00000100);
        wr(`MSD_OFF_WALK, 32'h00000003);
        rd_chk(`MSD_OFF_WALK, 32'h00000fff, 32'h00000b01);
        wr(`MSD_OFF_CTRL, 32'h00000000);
        wr_st(`MSD_OFF_AUX, 32'h00000111, 32'h00000008, 32'h00000008);
        wr_st(`MSD_OFF_AUX, 32'h00000211, 32'h00000008, 32'h00000000);
        wr_st(`MSD_OFF_REF0, 32'h00000800, 32'h00000010, 32'h00000010);
        wr_st(`MSD_OFF_REF0, 32'h07fff800, 32'h00000010, 32'h00000000);
        wr(`MSD_OFF_CTRL, 32'h00000700);
        wr_st(`MSD_OFF_SKIP, 32'h00100000, 32'h00000040, 32'h00000040);
        wr_st(`MSD_OFF_CTRL, 32'h00000000, 32'h00000040, 32'h00000000);
        wr(`MSD_OFF_AUX, 32'h00000000);
        wr(`MSD_OFF_SKIP, 32'h01000000);
        for (int i = 0; i < 4; i++)
        begin
            j = i[1:0];
            wr_st(`MSD_OFF_CTRL, {24'h0, j, 6'h0}, 32'h00c00080,
                {8'h0, j[0], j[1], 14'h0, ^j, 7'h0});
            wr_st(`MSD_OFF_CTRL, {30'h0, j}, (j == 2'h2) ? 32'h00000004 : 32'h00300004,
                (j == 2'h2) ? 32'h00000004 : {10'h0, j[0], j[1], 20'h0});
        end
        wr(`MSD_OFF_CTRL, 32'h00000000);
        wr_st(`MSD_OFF_SKIP, 32'ha5f00000, 32'h000fff20, 32'h0006a500);
        wr_st(`MSD_OFF_AUX, 32'h00000003, 32'h000fff00, 32'h000d0000);
        wr(`MSD_OFF_AUX, 32'h00000000);
        wr_st(`MSD_OFF_SKIP, 32'hfc000000, 32'h00000020, 32'h00000020);
        wr(`MSD_OFF_AUX, 32'h10000000);
        wr_st(`MSD_OFF_SKIP, 32'h55000000, 32'h00000020, 32'h00000000);
        wr(`MSD_OFF_AUX, 32'h00000001);
        for (int k = 0; k < 9; k++)
        begin
            t = remap_tab[k];
            wr(`MSD_OFF_CTRL, {26'h0, t[12:11], 4'h0});
            wr(`MSD_OFF_MAP, {23'h0, t[10], 3'h0, t[9:5]});
            rd_chk(`MSD_OFF_MAP, 32'h001f0000, {11'h0, t[4:0], 16'h0});
        end
        wr_st(`MSD_OFF_CTRL, 32'h00000030, 32'h00000002, 32'h00000002);
        wr_st(`MSD_OFF_AUX, 32'h00000002, 32'h00000002, 32'h00000002);
        wr(`MSD_OFF_PIC, 32'h00100020);
        wr(`MSD_OFF_REF0, 32'h0000001e);
        wr(`MSD_OFF_CLAMP, 32'h00001405);
        rd_chk(`MSD_OFF_CLAMP, 32'hffffffff, 32'h000f001f);
        wr(`MSD_OFF_REF0, 32'h00000000);
        wr(`MSD_OFF_CLAMP, 32'h0000fdfd);
        rd_chk(`MSD_OFF_CLAMP, 32'hffffffff, 32'h00000000);
        wr(`MSD_OFF_REF1, 32'h00050000);
        wr(`MSD_OFF_CLAMP, 32'h00010203);
        rd_chk(`MSD_OFF_CLAMP, 32'hffffffff, 32'h00070003);
        u_iss.xfer(1'b0, 8'h2c, 32'h00000000, q, e);
        check({31'h0, e}, 32'h00000001);
        check(q, 32'h00000000);
        end_sim();
    end
endmodule : tb_msd_decoder
`default_nettype wire
